// [logic/pcel_pkg.sv]
// Overview of operation
// - loads and stores use byte order from effective endianness; 0 little, 1 big
// - effective endianness is reset memory endianness XOR user endian swap
// - endian swap active only with control swap bit set in user mode
// - a linked load sets the link reservation flag
// - conditional store succeeds only while the reservation flag is set
// - any event breaking atomicity of the reserved location clears the flag, unless a linked load retires in the same time
// - exception return clears the link reservation flag
// - undelayed effects land in the instruction's own instruction time
// - delayed result lands one instruction time later, with next instruction
// - state updates within one instruction apply in their sequential order
// - during execution the program counter holds the instruction's address
// - without a written value the counter advances 2 for short, else 4
// - taken branch loads target during delay slot time; delay slot runs first
// - link writes restart address to a register; exceptions to a system register
// - program counter is a full 64-bit address, all bits used
// - program counter relative address generation is supported
// - memory endianness fixed at reset, 0 little, 1 big; governs kernel too
package pcel_pkg;
	localparam int PCEL_AW = 8;
	localparam int PCEL_PCW = 64;
	// register byte offsets
	localparam logic [7:0] PCEL_CTRL_OFS = 8'h00;
	localparam logic [7:0] PCEL_STAT_OFS = 8'h04;
	localparam logic [7:0] PCEL_PCLO_OFS = 8'h08;
	localparam logic [7:0] PCEL_PCHI_OFS = 8'h0c;
	localparam logic [7:0] PCEL_RSLO_OFS = 8'h10;
	localparam logic [7:0] PCEL_RSHI_OFS = 8'h14;
	// control fields
	localparam int PCEL_CTRL_SWAP_BIT = 0;
	localparam int PCEL_CTRL_USER_BIT = 1;
	localparam logic [1:0] PCEL_CTRL_RST = 2'h0;
	// status fields
	localparam int PCEL_STAT_MEM_BIT = 0;
	localparam int PCEL_STAT_LS_BIT = 1;
	localparam int PCEL_STAT_LINK_BIT = 2;
	localparam int PCEL_STAT_BR_BIT = 3;
	// program counter steps and reset vector
	localparam logic [63:0] PCEL_STEP_SHORT = 64'h2;
	localparam logic [63:0] PCEL_STEP_LONG = 64'h4;
	localparam logic [63:0] PCEL_RESET_PC = 64'h0;
	localparam logic [1:0] PCEL_RESP_OKAY = 2'h0;
	localparam logic [1:0] PCEL_RESP_SLVERR = 2'h2;

	// one retiring instruction, presented for one instruction time
	typedef struct packed {
		logic valid;
		logic short16;
		logic linked_load;
		logic cond_store;
		logic exc_return;
		logic branch_taken;
		logic link;
		logic delayed;
		logic [63:0] target;
		logic [63:0] result;
		logic [63:0] pc_offset;
	} pcel_retire_t;

	// exception request
	typedef struct packed {
		logic take;
		logic [63:0] vector;
	} pcel_exc_t;
endpackage

// [logic/pcel_pc_seq.sv]
`timescale 1ns/1ns
// program counter sequencing with one branch delay slot
module pcel_pc_seq import pcel_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire pcel_retire_t rt,
	input wire pcel_exc_t exc,
	output logic [63:0] pc_reg,
	output logic branch_pending_reg,
	output logic [63:0] branch_pc_reg
);
	logic [63:0] target_reg;
	logic [63:0] step;
	logic [63:0] pc_next;

	// sequential step: short instructions advance by two
	assign step = rt.short16 ? PCEL_STEP_SHORT : PCEL_STEP_LONG;
	// pending branch wins over the plain increment in the delay slot time
	assign pc_next = branch_pending_reg ? target_reg : pc_reg + step;

	// counter only moves at an instruction time boundary
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_reg <= PCEL_RESET_PC;
			branch_pending_reg <= 1'b0;
			target_reg <= PCEL_RESET_PC;
			branch_pc_reg <= PCEL_RESET_PC;
		end else if (ce) begin
			if (exc.take) begin
				pc_reg <= exc.vector;
				branch_pending_reg <= 1'b0;
			end else if (rt.valid) begin
				pc_reg <= pc_next;
				// a branch in a delay slot is not honoured
				branch_pending_reg <= rt.branch_taken && !branch_pending_reg;
				if (rt.branch_taken && !branch_pending_reg) begin
					target_reg <= rt.target;
					branch_pc_reg <= pc_reg;
				end
			end
		end
	end

	delay_slot_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && rt.valid && !exc.take && branch_pending_reg
		|=> pc_reg == $past(target_reg) && !branch_pending_reg)
		else $error("delay slot did not load branch target");

	step_short_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && rt.valid && !exc.take && !branch_pending_reg && rt.short16
		|=> pc_reg == $past(pc_reg) + 64'h2)
		else $error("short instruction did not advance by two");

	step_long_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && rt.valid && !exc.take && !branch_pending_reg && !rt.short16
		|=> pc_reg == $past(pc_reg) + 64'h4)
		else $error("long instruction did not advance by four");

	pc_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(!ce || (!rt.valid && !exc.take)) |=> $stable(pc_reg))
		else $error("counter moved outside an instruction time");
endmodule

// [logic/pcel_core.sv]
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
// architectural state: endianness, link reservation, pc, delayed results
module pcel_core import pcel_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic reset_memory_big_endian,
	input wire pcel_retire_t rt,
	input wire pcel_exc_t exc,
	input wire logic atomic_break,
	output logic [63:0] pc,
	output logic load_store_big_endian,
	output logic link_reservation_flag,
	output logic sc_success,
	output logic sc_done,
	output logic gpr_link_valid,
	output logic [63:0] gpr_link_data,
	output logic epc_valid,
	output logic [63:0] epc_data,
	output logic dly_wr_valid,
	output logic [63:0] dly_wr_data,
	output logic [63:0] pc_rel_addr,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic mem_big_reg;
	logic [1:0] ctrl_reg;
	logic ls_big_reg;
	logic link_reg;
	logic sc_success_reg;
	logic sc_done_reg;
	logic gpr_valid_reg;
	logic [63:0] gpr_data_reg;
	logic epc_valid_reg;
	logic [63:0] epc_data_reg;
	logic [63:0] restart_reg;
	logic dly_pending_reg;
	logic [63:0] dly_data_reg;
	logic dly_valid_reg;
	logic [63:0] dly_out_reg;
	logic [63:0] pc_rel_reg;
	logic [63:0] pc_cur;
	logic branch_pending;
	logic [63:0] branch_pc;
	logic user_endian_swap;
	logic ls_big_next;
	logic link_next;
	logic [63:0] step;
	logic [63:0] restart_exc;
	logic retire;
	logic awready_reg;
	logic wready_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic arready_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_go;
	logic wr_ctrl;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_mux;
	logic [31:0] stat_word;

	pcel_pc_seq u_pc (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.rt(rt),
		.exc(exc),
		.pc_reg(pc_cur),
		.branch_pending_reg(branch_pending),
		.branch_pc_reg(branch_pc)
	);

	// endianness decode
	assign user_endian_swap = ctrl_reg[PCEL_CTRL_SWAP_BIT]
		&& ctrl_reg[PCEL_CTRL_USER_BIT];
	assign ls_big_next = mem_big_reg ^ user_endian_swap;

	// memory endianness is a strap caught while reset is held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mem_big_reg <= reset_memory_big_endian;
			ls_big_reg <= 1'b0;
		end else if (ce) begin
			ls_big_reg <= ls_big_next;
		end
	end

	// reservation: set has priority so a linked load is never lost
	assign retire = ce && rt.valid && !exc.take;
	always_comb begin
		link_next = link_reg;
		if (atomic_break) begin
			link_next = 1'b0;
		end
		if (retire && (rt.exc_return || rt.cond_store)) begin
			link_next = 1'b0;
		end
		if (retire && rt.linked_load) begin
			link_next = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_reg <= 1'b0;
			sc_success_reg <= 1'b0;
			sc_done_reg <= 1'b0;
		end else if (ce) begin
			link_reg <= link_next;
			sc_done_reg <= retire && rt.cond_store;
			// flag is sampled before this instruction's own clear
			sc_success_reg <= retire && rt.cond_store && link_reg;
		end
	end

	// restart addresses: link skips the delay slot, exceptions restart
	// at the branch when caught in its slot
	assign step = rt.short16 ? PCEL_STEP_SHORT : PCEL_STEP_LONG;
	assign restart_exc = branch_pending ? branch_pc : pc_cur;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gpr_valid_reg <= 1'b0;
			gpr_data_reg <= PCEL_RESET_PC;
			epc_valid_reg <= 1'b0;
			epc_data_reg <= PCEL_RESET_PC;
			restart_reg <= PCEL_RESET_PC;
			pc_rel_reg <= PCEL_RESET_PC;
		end else if (ce) begin
			gpr_valid_reg <= retire && rt.link;
			epc_valid_reg <= exc.take;
			if (retire && rt.link) begin
				gpr_data_reg <= pc_cur + step + step;
				restart_reg <= pc_cur + step + step;
			end
			if (exc.take) begin
				epc_data_reg <= restart_exc;
				restart_reg <= restart_exc;
			end
			if (retire) begin
				pc_rel_reg <= pc_cur + rt.pc_offset;
			end
		end
	end

	// delayed result waits for the next instruction time; order against
	// that instruction's own writes is left to software to avoid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dly_pending_reg <= 1'b0;
			dly_data_reg <= 64'h0;
			dly_valid_reg <= 1'b0;
			dly_out_reg <= 64'h0;
		end else if (ce) begin
			dly_valid_reg <= retire && dly_pending_reg;
			if (retire && dly_pending_reg) begin
				dly_out_reg <= dly_data_reg;
			end
			if (exc.take) begin
				dly_pending_reg <= 1'b0;
			end else if (retire) begin
				dly_pending_reg <= rt.delayed;
				if (rt.delayed) begin
					dly_data_reg <= rt.result;
				end
			end
		end
	end

	// register bus decode
	assign wr_go = !awready_reg && !wready_reg && !bvalid_reg;
	assign wr_ctrl = awaddr_reg == PCEL_CTRL_OFS;
	assign wr_hit = wr_ctrl || awaddr_reg == PCEL_STAT_OFS
		|| awaddr_reg == PCEL_PCLO_OFS || awaddr_reg == PCEL_PCHI_OFS
		|| awaddr_reg == PCEL_RSLO_OFS || awaddr_reg == PCEL_RSHI_OFS;
	assign stat_word = {28'h0, branch_pending, link_reg, ls_big_reg,
		mem_big_reg};
	assign rd_hit = s_axi_araddr == PCEL_CTRL_OFS
		|| s_axi_araddr == PCEL_STAT_OFS || s_axi_araddr == PCEL_PCLO_OFS
		|| s_axi_araddr == PCEL_PCHI_OFS || s_axi_araddr == PCEL_RSLO_OFS
		|| s_axi_araddr == PCEL_RSHI_OFS;
	assign rd_mux =
		(s_axi_araddr == PCEL_CTRL_OFS) ? {30'h0, ctrl_reg} :
		(s_axi_araddr == PCEL_STAT_OFS) ? stat_word :
		(s_axi_araddr == PCEL_PCLO_OFS) ? pc_cur[31:0] :
		(s_axi_araddr == PCEL_PCHI_OFS) ? pc_cur[63:32] :
		(s_axi_araddr == PCEL_RSLO_OFS) ? restart_reg[31:0] :
		(s_axi_araddr == PCEL_RSHI_OFS) ? restart_reg[63:32] : 32'h0;

	// write channel: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			bvalid_reg <= 1'b0;
			bresp_reg <= PCEL_RESP_OKAY;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			ctrl_reg <= PCEL_CTRL_RST;
		end else if (ce) begin
			if (s_axi_awvalid && awready_reg) begin
				awaddr_reg <= s_axi_awaddr;
				awready_reg <= 1'b0;
			end
			if (s_axi_wvalid && wready_reg) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				wready_reg <= 1'b0;
			end
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? PCEL_RESP_OKAY : PCEL_RESP_SLVERR;
				if (wr_ctrl && wstrb_reg[0]) begin
					ctrl_reg <= wdata_reg[1:0];
				end
			end
			if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// read channel: data registered on address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= PCEL_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && arready_reg) begin
				arready_reg <= 1'b0;
				rvalid_reg <= 1'b1;
				rdata_reg <= rd_mux;
				rresp_reg <= rd_hit ? PCEL_RESP_OKAY : PCEL_RESP_SLVERR;
			end
			if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	assign pc = pc_cur;
	assign load_store_big_endian = ls_big_reg;
	assign link_reservation_flag = link_reg;
	assign sc_success = sc_success_reg;
	assign sc_done = sc_done_reg;
	assign gpr_link_valid = gpr_valid_reg;
	assign gpr_link_data = gpr_data_reg;
	assign epc_valid = epc_valid_reg;
	assign epc_data = epc_data_reg;
	assign dly_wr_valid = dly_valid_reg;
	assign dly_wr_data = dly_out_reg;
	assign pc_rel_addr = pc_rel_reg;
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	endian_xor_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce |=> ls_big_reg == ($past(mem_big_reg) ^ $past(ctrl_reg[0]
		&& ctrl_reg[1])))
		else $error("load store endianness is not strap xor swap");

	swap_user_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && !ctrl_reg[PCEL_CTRL_USER_BIT] |=> ls_big_reg == mem_big_reg)
		else $error("endian swap active outside user mode");

	ll_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire && rt.linked_load |=> link_reg)
		else $error("linked load did not set reservation");

	sc_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire && rt.cond_store |=> sc_done_reg
		&& sc_success_reg == $past(link_reg))
		else $error("conditional store result disagrees with flag");

	break_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && atomic_break && !(retire && rt.linked_load) |=> !link_reg)
		else $error("atomicity break left reservation set");

	eret_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire && rt.exc_return && !rt.linked_load |=> !link_reg)
		else $error("exception return left reservation set");

	dly_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire && rt.delayed |=> dly_pending_reg
		&& dly_data_reg == $past(rt.result))
		else $error("delayed result was not held for the next instruction");

	delayed_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire && dly_pending_reg
		|=> dly_valid_reg && dly_out_reg == $past(dly_data_reg))
		else $error("delayed result missed the next instruction time");

	link_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire && rt.link |=> gpr_valid_reg
		&& gpr_data_reg == $past(pc_cur) + 2 * $past(step))
		else $error("link restart address wrong");

	epc_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && exc.take |=> epc_valid_reg && epc_data_reg == $past(restart_exc))
		else $error("exception restart address not written");

	pc_rel_a: assert property (@(posedge aclk) disable iff (!aresetn)
		retire |=> pc_rel_reg == $past(pc_cur) + $past(rt.pc_offset))
		else $error("pc relative address wrong");
endmodule

// [tb/pcel_fetch_model.sv]
`timescale 1ns/1ns
// fetch and load/store side: hands over retire records and traps
module pcel_fetch_model import pcel_pkg::*; (
	input wire logic aclk,
	output pcel_retire_t rt,
	output pcel_exc_t exc
);
	initial begin
		rt = '0;
		exc = '0;
	end
	// one record per instruction time, strictly one after another
	task automatic issue(input pcel_retire_t r);
		pcel_retire_t idle;
		idle = ~r;
		idle.valid = 1'h0;
		@(posedge aclk);
		rt <= r;
		@(posedge aclk);
		// released fields show junk, not the last record
		rt <= idle;
	endtask
	// trap request lasts exactly one instruction time
	task automatic trap(input logic [63:0] v);
		@(posedge aclk);
		exc <= {1'h1, v};
		@(posedge aclk);
		exc <= {1'h0, ~v};
	endtask
endmodule

// [tb/pcel_core_tb_top.sv]
`timescale 1ns/1ns
// sequence-level bench for the architectural state block
module pcel_core_tb_top import pcel_pkg::*; ;
	localparam logic [6:0] F_SHORT = 7'h40;
	localparam logic [6:0] F_LL = 7'h20;
	localparam logic [6:0] F_SC = 7'h10;
	localparam logic [6:0] F_ER = 7'h08;
	localparam logic [6:0] F_BR = 7'h04;
	localparam logic [6:0] F_LNK = 7'h02;
	localparam logic [6:0] F_DLY = 7'h01;
	localparam logic [63:0] T_FAR = 64'hfedc_ba98_7654_3210;
	localparam logic [63:0] V_EXC = 64'h0000_0000_0000_0180;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic ce = 1'h1;
	logic reset_memory_big_endian = 1'h0;
	logic atomic_break = 1'h0;
	pcel_retire_t rt;
	pcel_exc_t exc;
	logic [63:0] pc, gpr_link_data, epc_data, dly_wr_data, pc_rel_addr;
	logic load_store_big_endian, link_reservation_flag;
	logic sc_success, sc_done, gpr_link_valid, epc_valid, dly_wr_valid;
	logic [7:0] s_axi_awaddr = 8'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [63:0] ep;
	logic [31:0] rd;
	logic [1:0] rs;

	always #5 aclk = ~aclk;
	pcel_core uut (.*);
	pcel_fetch_model fm (.aclk, .rt, .exc);

	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// strap only counts while reset is held
	task automatic reset_dut(input logic s);
		@(posedge aclk);
		aresetn <= 1'h0;
		reset_memory_big_endian <= s;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		ep = PCEL_RESET_PC;
	endtask
	// readiness sampled mid-cycle; flops only move on edges
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, b;
		b = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'h1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!b) begin
			@(negedge aclk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid === 1'h1;
			if (b)
				rs = s_axi_bresp;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'h0;
			if (w)
				s_axi_wvalid <= 1'h0;
			if (b)
				s_axi_bready <= 1'h0;
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar, v;
		v = 1'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!v) begin
			@(negedge aclk);
			ar = s_axi_arvalid && s_axi_arready;
			v = s_axi_rvalid === 1'h1;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'h0;
			if (v)
				s_axi_rready <= 1'h0;
		end
	endtask
	// retire one instruction; expected pc follows the plain step
	task automatic run(input logic [6:0] f, input logic [63:0] t,
		input logic [63:0] r);
		pcel_retire_t x;
		x = '0;
		x.valid = 1'h1;
		{x.short16, x.linked_load, x.cond_store, x.exc_return} = f[6:3];
		{x.branch_taken, x.link, x.delayed} = f[2:0];
		x.target = t;
		x.result = r;
		x.pc_offset = t;
		fm.issue(x);
		#1;
		ep = ep + (f[6] ? PCEL_STEP_SHORT : PCEL_STEP_LONG);
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			wrap_up();
		end
	end

	initial begin
		reset_dut(1'h0);
		#1;
		chk(pc, PCEL_RESET_PC);
		chk(link_reservation_flag, 1'h0);
		axi_rd(PCEL_CTRL_OFS, rd, rs);
		chk({rs, rd}, {PCEL_RESP_OKAY, 32'h0});
		axi_rd(8'h20, rd, rs);
		chk({rs, rd}, {PCEL_RESP_SLVERR, 32'h0});
		// unmapped write is refused and leaves control untouched
		axi_wr(8'h20, 32'h3);
		chk(rs, PCEL_RESP_SLVERR);
		axi_rd(PCEL_CTRL_OFS, rd, rs);
		chk({rs, rd}, {PCEL_RESP_OKAY, 32'h0});
		$display("test reset done");
		// every strap and control combination
		for (int s = 0; s < 2; s++) begin
			reset_dut(s[0]);
			for (int c = 0; c < 4; c++) begin
				axi_wr(PCEL_CTRL_OFS, 32'(c));
				chk(rs, PCEL_RESP_OKAY);
				repeat (2) @(posedge aclk);
				#1;
				chk(load_store_big_endian, s[0] ^ (c == 3));
			end
			axi_rd(PCEL_STAT_OFS, rd, rs);
			chk(rd[1:0], {~s[0], s[0]});
		end
		$display("test endian done");
		axi_wr(PCEL_CTRL_OFS, 32'h0);
		run(7'h0, 64'h10, 64'h0);
		chk(pc, ep);
		chk(pc_rel_addr, 64'h10);
		run(F_SHORT, 64'h0, 64'h0);
		chk(pc, ep);
		// a retire offered while the clock enable is low is not taken
		@(posedge aclk);
		ce <= 1'h0;
		run(7'h0, 64'h0, 64'h0);
		ep = ep - PCEL_STEP_LONG;
		chk(pc, ep);
		@(posedge aclk);
		ce <= 1'h1;
		$display("test step done");
		// branch in the delay slot must be ignored
		run(F_BR, T_FAR, 64'h0);
		chk(pc, ep);
		run(F_BR, 64'h40, 64'h0);
		ep = T_FAR;
		chk(pc, ep);
		axi_rd(PCEL_PCHI_OFS, rd, rs);
		chk(rd, ep[63:32]);
		run(7'h0, 64'h0, 64'h0);
		chk(pc, ep);
		$display("test branch done");
		chk({gpr_link_valid, 64'h0}, {1'h0, 64'h0});
		run(F_LNK, 64'h0, 64'h0);
		chk({gpr_link_valid, gpr_link_data}, {1'h1, ep + 64'h4});
		run(F_DLY, 64'h0, 64'h1234);
		chk(dly_wr_valid, 1'h0);
		run(7'h0, 64'h0, 64'h0);
		chk({dly_wr_valid, dly_wr_data}, {1'h1, 64'h1234});
		// delayed result cut off by a trap
		run(F_DLY, 64'h0, 64'h5678);
		fm.trap(V_EXC);
		#1;
		chk({epc_valid, epc_data}, {1'h1, ep});
		chk(pc, V_EXC);
		run(7'h0, 64'h0, 64'h0);
		chk(dly_wr_valid, 1'h0);
		$display("test link done");
		run(F_LL, 64'h0, 64'h0);
		chk(link_reservation_flag, 1'h1);
		run(F_SC, 64'h0, 64'h0);
		chk({sc_done, sc_success, link_reservation_flag}, 3'h6);
		run(F_SC, 64'h0, 64'h0);
		chk({sc_done, sc_success, link_reservation_flag}, 3'h4);
		run(F_LL, 64'h0, 64'h0);
		@(posedge aclk);
		atomic_break <= 1'h1;
		@(posedge aclk);
		atomic_break <= 1'h0;
		#1;
		chk(link_reservation_flag, 1'h0);
		run(F_LL, 64'h0, 64'h0);
		run(F_ER, 64'h0, 64'h0);
		chk(link_reservation_flag, 1'h0);
		// set and break in the same instruction time
		@(posedge aclk);
		atomic_break <= 1'h1;
		run(F_LL, 64'h0, 64'h0);
		chk(link_reservation_flag, 1'h1);
		@(posedge aclk);
		atomic_break <= 1'h0;
		$display("test reservation done");
		wrap_up();
	end
endmodule
